//--- wake_frame_id_filter_regs.sv
`timescale 1ns/1ps
module wake_frame_id_filter_regs
  import wake_filter_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic soft_reset_in,
  input wire logic restart_in,
  input wire reg_req_t reg_req_in,
  output logic [REG_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire can_frame_t frame_in,
  input wire logic cfg_valid_set_in,
  input wire logic wake_event_in,
  output logic cfg_valid_out,
  output logic frame_match_out
);

  typedef struct packed {
    logic [REG_W-1:0] high_id;
    logic [REG_W-1:0] low_id;
    logic [REG_W-1:0] high_mask;
    logic cfg_valid;
    logic [REG_W-1:0] rdata;
    logic rvalid;
    logic match;
  } filt_state_t;

  filt_state_t state_r;
  filt_state_t state_nxt;
  logic id_match;

  // address decode shared by the valid-flag clear and the checks
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    return (addr == ADDR_HIGH_ID) || (addr == ADDR_LOW_ID) ||
           (addr == ADDR_HIGH_MASK);
  endfunction

  wake_id_matcher u_matcher (
    .high_id_in(state_r.high_id),
    .low_id_in(state_r.low_id),
    .high_mask_in(state_r.high_mask),
    .frame_id_in(frame_in.id),
    .frame_rtr_in(frame_in.rtr),
    .frame_ide_in(frame_in.ide),
    .match_out(id_match)
  );

  // next state: resets, register writes, reads, valid flag, match
  always_comb begin
    state_nxt = state_r;
    state_nxt.rvalid = 1'b0;
    state_nxt.match = 1'b0;
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        ADDR_HIGH_ID: state_nxt.high_id = reg_req_in.wdata;
        ADDR_LOW_ID: state_nxt.low_id = reg_req_in.wdata & LOW_WRITE_MASK;
        ADDR_HIGH_MASK: state_nxt.high_mask = reg_req_in.wdata;
        default: state_nxt.high_id = state_r.high_id;
      endcase
    end
    if (reg_req_in.rd) begin
      state_nxt.rvalid = 1'b1;
      unique case (reg_req_in.addr)
        ADDR_HIGH_ID: state_nxt.rdata = state_r.high_id;
        ADDR_LOW_ID: state_nxt.rdata = state_r.low_id & LOW_WRITE_MASK;
        ADDR_HIGH_MASK: state_nxt.rdata = state_r.high_mask;
        default: state_nxt.rdata = RDATA_IDLE;
      endcase
    end
    // cleared on wake or config change, host set wins
    if (wake_event_in || (reg_req_in.wr && is_mapped(reg_req_in.addr))) begin
      state_nxt.cfg_valid = 1'b0;
    end
    if (cfg_valid_set_in) begin
      state_nxt.cfg_valid = 1'b1;
    end
    // frame compared only while configuration is valid
    state_nxt.match = frame_in.valid && state_r.cfg_valid && id_match;
    // restart keeps fields and forces bit 7 low
    if (restart_in) begin
      state_nxt.low_id[LOW_RES_POS] = 1'b0;
    end
    // power-on or soft reset clears everything
    if (srst_in || soft_reset_in) begin
      state_nxt = '0;
      state_nxt.low_id = REG_RESET;
      state_nxt.high_id = REG_RESET;
      state_nxt.high_mask = REG_RESET;
      state_nxt.rdata = RDATA_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    state_r <= state_nxt;
  end

  // outputs straight from the state register
  assign reg_rdata_out = state_r.rdata;
  assign reg_rvalid_out = state_r.rvalid;
  assign cfg_valid_out = state_r.cfg_valid;
  assign frame_match_out = state_r.match;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  // quiet cycle: no power-on or soft reset
  sequence quiet_s;
    !soft_reset_in && !srst_in;
  endsequence

  sequence cfg_write_s;
    quiet_s and (reg_req_in.wr && is_mapped(reg_req_in.addr) && !cfg_valid_set_in);
  endsequence

  sequence cfg_dropped_s;
    !cfg_valid_out ##1 (!cfg_valid_out || $past(cfg_valid_set_in));
  endsequence

  sequence low_write_s;
    quiet_s and (reg_req_in.wr && reg_req_in.addr == ADDR_LOW_ID);
  endsequence

  chk_low_bit_seven: assert property (
    state_r.low_id[LOW_RES_POS] == 1'b0)
    else $error("reserved bit of lower identifier is set");

  chk_low_read_map: assert property (
    (quiet_s and (reg_req_in.rd && reg_req_in.addr == ADDR_LOW_ID)) |=>
      reg_rvalid_out && reg_rdata_out[LOW_RES_POS] == 1'b0 &&
      reg_rdata_out == $past(state_r.low_id))
    else $error("lower identifier read back wrong");

  chk_rtr_store: assert property (
    low_write_s |=> state_r.low_id[LOW_RTR_POS] == $past(reg_req_in.wdata[LOW_RTR_POS]))
    else $error("frame type bit not stored");

  chk_ide_store: assert property (
    low_write_s |=> state_r.low_id[LOW_IDE_POS] == $past(reg_req_in.wdata[LOW_IDE_POS]))
    else $error("identifier format bit not stored");

  chk_reset_clear: assert property (disable iff (1'b0)
    (srst_in || soft_reset_in) |=>
      state_r.low_id == REG_RESET && state_r.high_mask == REG_RESET &&
      state_r.high_id == REG_RESET && !cfg_valid_out)
    else $error("reset did not clear filter registers");

  chk_restart_keep: assert property (
    (quiet_s and (restart_in && !reg_req_in.wr)) |=>
      state_r.low_id == $past(state_r.low_id) && state_r.high_mask == $past(state_r.high_mask))
    else $error("restart changed configuration");

  chk_mask_store: assert property (
    (quiet_s and (reg_req_in.wr && reg_req_in.addr == ADDR_HIGH_MASK)) |=>
      state_r.high_mask == $past(reg_req_in.wdata))
    else $error("upper mask not stored");

  chk_addr_decode: assert property (
    (quiet_s and (reg_req_in.wr && !is_mapped(reg_req_in.addr))) |=>
      $stable(state_r.low_id) && $stable(state_r.high_id) && $stable(state_r.high_mask))
    else $error("unmapped write changed a register");

  chk_high_id_store: assert property (
    (quiet_s and (reg_req_in.wr && reg_req_in.addr == ADDR_HIGH_ID)) |=>
      state_r.high_id == $past(reg_req_in.wdata))
    else $error("upper identifier not stored");

  chk_cfg_clear: assert property (
    cfg_write_s |=> cfg_dropped_s)
    else $error("config write left valid flag set");

  chk_cfg_set: assert property (
    (quiet_s and cfg_valid_set_in) |=> cfg_valid_out [*1])
    else $error("host set of valid flag lost");

  chk_match_flags: assert property (
    frame_match_out |->
      $past(frame_in.valid) && $past(state_r.cfg_valid) &&
      $past(frame_in.rtr) == $past(state_r.low_id[LOW_RTR_POS]) &&
      $past(frame_in.ide) == $past(state_r.low_id[LOW_IDE_POS]))
    else $error("match raised without valid config or equal flags");

  // a frame equal to the stored setup in every bit
  sequence exact_frame_s;
    quiet_s and (frame_in.valid && cfg_valid_out &&
      frame_in.rtr == state_r.low_id[LOW_RTR_POS] &&
      frame_in.ide == state_r.low_id[LOW_IDE_POS] &&
      frame_in.id == {state_r.high_id, state_r.low_id[LOW_ID_HI_MSB:LOW_ID_HI_LSB],
                      state_r.low_id[LOW_ID_LO_MSB:LOW_ID_LO_LSB]});
  endsequence

  chk_match_exact: assert property (
    exact_frame_s |=> frame_match_out)
    else $error("exact frame under valid config did not match");

  chk_match_upper: assert property (
    (frame_match_out && $past(frame_in.ide)) |->
      (($past(frame_in.id[ID_W-1:LOW_ID_BITS]) ^ $past(state_r.high_id)) &
       $past(state_r.high_mask)) == '0 &&
      $past(frame_in.id[LOW_ID_BITS-1:0]) ==
      {$past(state_r.low_id[LOW_ID_HI_MSB:LOW_ID_HI_LSB]),
       $past(state_r.low_id[LOW_ID_LO_MSB:LOW_ID_LO_LSB])})
    else $error("extended match with a compared identifier bit different");

  chk_wake_clear: assert property (
    (quiet_s and (wake_event_in && !cfg_valid_set_in)) |=> !cfg_valid_out)
    else $error("wake event left valid flag set");

  chk_rvalid_pulse: assert property (
    (quiet_s and !reg_req_in.rd) |=> !reg_rvalid_out)
    else $error("read answer without a read");

  chk_unmapped_read: assert property (
    (quiet_s and (reg_req_in.rd && !is_mapped(reg_req_in.addr))) |=>
      reg_rvalid_out && reg_rdata_out == RDATA_IDLE)
    else $error("unmapped read returned data");

  chk_rdata_hold: assert property (
    (quiet_s and !reg_req_in.rd) |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");

endmodule

//--- wake_filter_pkg.sv
// Summary of operation
// - identifier bits 12..5 and 4..0 packed; bit 7 zero
// - bit 1 selects data or remote frame
// - bit 0 selects standard or extended identifier
// - power-on or soft reset clears lower identifier
// - restart keeps fields, forces bit 7 zero
// - mask bits 15..0 enable compare of 28..13; standard frames use only mask bits 15..5 for 28..18
// - registers answer at their own 7-bit addresses
// - upper identifier register holds bits 28..13
// - host sets valid flag; device clears on changes
package wake_filter_pkg;

  localparam int REG_W = 16;
  localparam int ADDR_W = 7;
  localparam int ID_W = 29;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_HIGH_ID = 7'h32;
  localparam logic [ADDR_W-1:0] ADDR_LOW_ID = 7'h33;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_MASK = 7'h34;

  // lower identifier register layout
  localparam int LOW_ID_HI_MSB = 15;
  localparam int LOW_ID_HI_LSB = 8;
  localparam int LOW_RES_POS = 7;
  localparam int LOW_ID_LO_MSB = 6;
  localparam int LOW_ID_LO_LSB = 2;
  localparam int LOW_RTR_POS = 1;
  localparam int LOW_IDE_POS = 0;
  localparam logic [REG_W-1:0] LOW_WRITE_MASK = 16'hff7f;

  // reset values
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [REG_W-1:0] RDATA_IDLE = 16'h0000;

  // identifier split: low register holds 13 bits, standard frames use 28..18
  localparam int LOW_ID_BITS = 13;
  localparam int STD_ID_LSB = 18;
  localparam int STD_MASK_LSB = STD_ID_LSB - LOW_ID_BITS;
  localparam logic [LOW_ID_BITS-1:0] LOW_CARE_ALL = 13'h1fff;
  localparam logic [STD_ID_LSB-1:0] STD_CARE_NONE = 18'h00000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] id;
    logic rtr;
    logic ide;
  } can_frame_t;

endpackage

//--- wake_id_matcher.sv
`timescale 1ns/1ps
module wake_id_matcher
  import wake_filter_pkg::*;
(
  input wire logic [REG_W-1:0] high_id_in,
  input wire logic [REG_W-1:0] low_id_in,
  input wire logic [REG_W-1:0] high_mask_in,
  input wire logic [ID_W-1:0] frame_id_in,
  input wire logic frame_rtr_in,
  input wire logic frame_ide_in,
  output logic match_out
);

  logic [ID_W-1:0] expected_id;
  logic [ID_W-1:0] care;

  // expected identifier and the bits that take part in the compare
  always_comb begin
    expected_id = {high_id_in, low_id_in[LOW_ID_HI_MSB:LOW_ID_HI_LSB],
                   low_id_in[LOW_ID_LO_MSB:LOW_ID_LO_LSB]};
    // mask bit one includes the bit
    if (frame_ide_in) begin
      care = {high_mask_in, LOW_CARE_ALL};
    end else begin
      care = {high_mask_in[REG_W-1:STD_MASK_LSB], STD_CARE_NONE};
    end
    // identifier, type and format must agree
    match_out = (((frame_id_in ^ expected_id) & care) == '0) &&
                (frame_rtr_in == low_id_in[LOW_RTR_POS]) &&
                (frame_ide_in == low_id_in[LOW_IDE_POS]);
  end

endmodule

//--- can_node_model.sv
`timescale 1ns/1ps
module can_node_model
  import wake_filter_pkg::*;
(
  input wire logic clk_in,
  output can_frame_t frame_out
);
  initial frame_out = '0;
  // one frame for one cycle; after it the lines show the inverse, not a stale copy
  task automatic send(input logic [ID_W-1:0] id, input logic rtr, input logic ide);
    @(negedge clk_in);
    frame_out = {1'b1, id, rtr, ide};
    @(negedge clk_in);
    frame_out = {1'b0, ~id, ~rtr, ~ide};
  endtask
endmodule

//--- wake_frame_id_filter_regs_tb_top.sv
`timescale 1ns/1ps
module wake_frame_id_filter_regs_tb_top;
  import wake_filter_pkg::*;
  logic clk = 0, srst = 1, soft_rst = 0, restart = 0, set_p = 0, wake_p = 0;
  logic fv_d = 0, cfg_exp = 0, rvalid, cfg_valid, match;
  reg_req_t req = '0;
  can_frame_t frame;
  logic [REG_W-1:0] rdata, hi, lo, mk, q_rd[$];
  logic [ID_W-1:0] id;
  logic q_fm[$];
  int errors = 0, checks_done = 0, cycles = 0;
  always #5 clk = ~clk;
  wake_frame_id_filter_regs i_wake_frame_id_filter_regs (.clk_in(clk), .srst_in(srst),
    .soft_reset_in(soft_rst), .restart_in(restart), .reg_req_in(req), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .frame_in(frame), .cfg_valid_set_in(set_p),
    .wake_event_in(wake_p), .cfg_valid_out(cfg_valid), .frame_match_out(match));
  can_node_model i_can_node_model (.clk_in(clk), .frame_out(frame));
  task automatic chk(input logic [REG_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one register access; a read notes its expected word
  task automatic acc(input logic w, r, input logic [6:0] a, input logic [15:0] d, e);
    @(negedge clk);
    req = {w, r, a, d};
    if (r) q_rd.push_back(e);
    @(negedge clk);
    req = '0;
    if (w && a >= 7'h32 && a <= 7'h34) cfg_exp = 0;
  endtask
  task automatic flag(input logic s, w, exp);
    @(negedge clk);
    set_p = s;
    wake_p = w;
    @(negedge clk);
    set_p = 0;
    wake_p = 0;
    cfg_exp = exp;
    chk(cfg_valid, exp);
  endtask
  // expected match from the stored setup
  function automatic logic exp_m(input logic [ID_W-1:0] fid, input logic rtr, ide);
    logic [ID_W-1:0] d;
    d = fid ^ {hi, lo[15:8], lo[6:2]};
    if (rtr !== lo[1] || ide !== lo[0] || !cfg_exp) return 0;
    if (ide) return ((d[28:13] & mk) == 0) && (d[12:0] == 0);
    return (d[28:18] & mk[15:5]) == 0;
  endfunction
  task automatic frm(input logic [ID_W-1:0] fid, input logic rtr, ide);
    q_fm.push_back(exp_m(fid, rtr, ide));
    i_can_node_model.send(fid, rtr, ide);
  endtask
  // watcher: reads and frame answers against the oldest notes
  always @(posedge clk) begin
    #1;
    if (rvalid === 1'b1) chk(rdata, q_rd.pop_front());
    fv_d = frame.valid;
    if (fv_d === 1'b1) chk(match, q_fm.pop_front());
    else chk(match, 0);
    cycles++;
    if (cycles == 2000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h53ce));
    repeat (2) @(negedge clk);
    srst = 0;
    for (int a = 'h31; a < 'h36; a++) acc(0, 1, 7'(a), 0, 0);
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      hi = $urandom;
      lo = $urandom;
      mk = $urandom;
      acc(1, 0, ADDR_HIGH_ID, hi, 0);
      acc(1, 0, ADDR_LOW_ID, lo, 0);
      acc(1, 0, ADDR_HIGH_MASK, mk, 0);
      lo = lo & 16'hff7f;
      acc(0, 1, ADDR_HIGH_ID, 0, hi);
      acc(1, 1, ADDR_LOW_ID, ~lo, lo);
      lo = ~lo & 16'hff7f;
      acc(0, 1, ADDR_LOW_ID, 0, lo);
      acc(0, 1, ADDR_HIGH_MASK, 0, mk);
      frm({hi, lo[15:8], lo[6:2]}, lo[1], lo[0]);
      flag(1, 0, 1);
      for (int j = 0; j < 10; j++) begin
        id = {hi, lo[15:8], lo[6:2]};
        if (j[0]) id = id ^ (ID_W'(1) << ($urandom % 29));
        frm(id, lo[1] ^ (j == 6), lo[0] ^ (j == 8));
      end
      flag(1, 1, 1);
      flag(0, 1, 0);
      frm({hi, lo[15:8], lo[6:2]}, lo[1], lo[0]);
    end
    $display("test setup and match done");
    flag(1, 0, 1);
    @(negedge clk);
    restart = 1;
    @(negedge clk);
    restart = 0;
    acc(0, 1, ADDR_LOW_ID, 0, lo);
    acc(0, 1, ADDR_HIGH_MASK, 0, mk);
    $display("test restart done");
    @(negedge clk);
    soft_rst = 1;
    @(negedge clk);
    soft_rst = 0;
    cfg_exp = 0;
    chk(cfg_valid, 0);
    for (int a = 'h32; a < 'h35; a++) acc(0, 1, 7'(a), 0, 0);
    $display("test soft reset done");
    repeat (3) @(negedge clk);
    chk(REG_W'(q_rd.size()), 0);
    chk(REG_W'(q_fm.size()), 0);
    test_done();
  end
endmodule
